// [rtl/cmd_addr_pkg.sv]
// package: shared constants for the command/address link between a
// memory controller end and the memory device decode end.
// assumes both ends run on the same ref_clk_i and see the same pins.
package cmd_addr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W   = 14;
    localparam int BANK_W   = 3;
    localparam int MR_IDX_W = 2;

    // ------------------------------------------------------------
    // address field positions
    // ------------------------------------------------------------
    localparam int AUTO_PRE_BIT  = 10;
    localparam int CHOP_SEL_BIT  = 12;
    // mode register 0 burst length field
    localparam int MR0_BL_LSB    = 0;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // ------------------------------------------------------------
    // command codes {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_MRS  = 4'h0;
    localparam logic [3:0] CODE_REF  = 4'h1;
    localparam logic [3:0] CODE_PRE  = 4'h2;
    localparam logic [3:0] CODE_ACT  = 4'h3;
    localparam logic [3:0] CODE_WR   = 4'h4;
    localparam logic [3:0] CODE_ZQ   = 4'h6;
    localparam logic [3:0] CODE_RD   = 4'h5;
    localparam logic [3:0] CODE_NOP  = 4'h7;
    localparam logic [3:0] CODE_DESL = 4'h8;

    // ------------------------------------------------------------
    // decoded command kinds and reset values
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        K_NONE  = 3'h0,
        K_ACT   = 3'h1,
        K_RD    = 3'h2,
        K_WR    = 3'h3,
        K_PRE   = 3'h4,
        K_MRS   = 3'h5,
        K_OTHER = 3'h6
    } cmd_kind_t;

    localparam logic [13:0] MR_RESET = 14'h0000;
endpackage

// [rtl/cmd_addr_if.sv]
// interface: command, address and strobe pins between the two ends.
// assumes one shared clock; the strobe is driven by the device end.
`timescale 1ns/1ps
`default_nettype none
interface cmd_addr_if (
    input wire logic ref_clk_i
);
    logic                              cs_n;
    logic                              ras_n;
    logic                              cas_n;
    logic                              we_n;
    logic [cmd_addr_pkg::ADDR_W-1:0]   addr;
    logic [cmd_addr_pkg::BANK_W-1:0]   bank;
    logic                              dqs;
    logic                              dqs_n;
    logic                              dqs_oe;

    modport ctrl (
        input  ref_clk_i,
        output cs_n,
        output ras_n,
        output cas_n,
        output we_n,
        output addr,
        output bank,
        input  dqs,
        input  dqs_n,
        input  dqs_oe
    );
    modport dev (
        input  ref_clk_i,
        input  cs_n,
        input  ras_n,
        input  cas_n,
        input  we_n,
        input  addr,
        input  bank,
        output dqs,
        output dqs_n,
        output dqs_oe
    );
endinterface
`default_nettype wire

// [rtl/cmd_addr_decode.sv]
// device end: registers command and address pins on each rising edge,
// decodes the command and reports row, column, precharge, mode loads.
// assumes the controller end holds pins stable around the rising edge.
//
// Functional notes
// - activate row taken from address inputs
// - read/write: column address, bit 10 auto precharge
// - precharge bit 10: low one bank, high all
// - load mode writes address opcode to register
// - otf chop: bit 12 high eight, low four
// - bank inputs pick bank for bank commands
// - bank inputs pick mode register zero to three
// - inputs sampled only at rising clock edge
// - strobe timed from clock edges
// - command decoded from four strobes together
// - chip select high masks the command decoder
`timescale 1ns/1ps
`default_nettype none
module cmd_addr_decode (
    cmd_addr_if.dev                        pins,
    input  wire logic                      rst_i,
    input  wire logic                      strobe_en_i,
    output logic                           cmd_valid_o,
    output cmd_addr_pkg::cmd_kind_t        cmd_kind_o,
    output logic [cmd_addr_pkg::BANK_W-1:0] bank_o,
    output logic [cmd_addr_pkg::ADDR_W-1:0] row_o,
    output logic [cmd_addr_pkg::ADDR_W-1:0] col_o,
    output logic                           auto_pre_o,
    output logic                           pre_all_o,
    output logic                           burst8_o,
    output logic                           mr_load_o,
    output logic [cmd_addr_pkg::MR_IDX_W-1:0] mr_idx_o,
    output logic [cmd_addr_pkg::ADDR_W-1:0] mr0_o
);
    // ------------------------------------------------------------
    // input registers, one sample per rising edge
    // ------------------------------------------------------------
    logic [3:0]                          code_r;
    logic [cmd_addr_pkg::ADDR_W-1:0]     addr_r;
    logic [cmd_addr_pkg::BANK_W-1:0]     bank_r;

    // reset parks the code at deselect so nothing decodes from stale pins
    wire [3:0] code_nxt = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            code_r <= cmd_addr_pkg::CODE_DESL;
        end else begin
            code_r <= code_nxt;
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            addr_r <= '0;
            bank_r <= '0;
        end else begin
            addr_r <= pins.addr;
            bank_r <= pins.bank;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire deselect = code_r[3];
    wire is_act = !deselect && code_r == cmd_addr_pkg::CODE_ACT;
    wire is_rd  = !deselect && code_r == cmd_addr_pkg::CODE_RD;
    wire is_wr  = !deselect && code_r == cmd_addr_pkg::CODE_WR;
    wire is_pre = !deselect && code_r == cmd_addr_pkg::CODE_PRE;
    wire is_mrs = !deselect && code_r == cmd_addr_pkg::CODE_MRS;
    wire is_oth = !deselect && !is_act && !is_rd && !is_wr && !is_pre
                  && !is_mrs && code_r != cmd_addr_pkg::CODE_NOP;

    logic [cmd_addr_pkg::ADDR_W-1:0] mr0_r;
    wire [1:0] bl_mode = mr0_r[cmd_addr_pkg::MR0_BL_LSB +: 2];
    wire otf_on = bl_mode == cmd_addr_pkg::BL_OTF;
    // chop pin only matters when the mode register allows it
    wire b8_nxt = otf_on ? addr_r[cmd_addr_pkg::CHOP_SEL_BIT]
                         : (bl_mode != cmd_addr_pkg::BL_FIXED4);
    wire [cmd_addr_pkg::MR_IDX_W-1:0] idx_nxt =
        bank_r[cmd_addr_pkg::MR_IDX_W-1:0];

    cmd_addr_pkg::cmd_kind_t kind_nxt;
    assign kind_nxt = is_act ? cmd_addr_pkg::K_ACT :
                      is_rd  ? cmd_addr_pkg::K_RD  :
                      is_wr  ? cmd_addr_pkg::K_WR  :
                      is_pre ? cmd_addr_pkg::K_PRE :
                      is_mrs ? cmd_addr_pkg::K_MRS :
                      is_oth ? cmd_addr_pkg::K_OTHER :
                               cmd_addr_pkg::K_NONE;

    // ------------------------------------------------------------
    // decoded outputs
    // ------------------------------------------------------------
    wire bank_cmd = is_act || is_rd || is_wr || is_pre;
    wire rw_cmd   = is_rd || is_wr;
    wire any_cmd  = kind_nxt != cmd_addr_pkg::K_NONE;

    // pulses stand one cycle; data fields hold until the next command
    // of their own kind, so a slow consumer may still read them later
    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_kind_o  <= cmd_addr_pkg::K_NONE;
            mr_load_o   <= 1'b0;
        end else begin
            cmd_valid_o <= any_cmd;
            cmd_kind_o  <= kind_nxt;
            mr_load_o   <= is_mrs;
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            bank_o <= '0;
        end else if (bank_cmd) begin
            bank_o <= bank_r;
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            row_o <= '0;
        end else if (is_act) begin
            row_o <= addr_r;
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            col_o      <= '0;
            auto_pre_o <= 1'b0;
            burst8_o   <= 1'b1;
        end else if (rw_cmd) begin
            col_o      <= addr_r;
            auto_pre_o <= addr_r[cmd_addr_pkg::AUTO_PRE_BIT];
            burst8_o   <= b8_nxt;
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            pre_all_o <= 1'b0;
        end else if (is_pre) begin
            pre_all_o <= addr_r[cmd_addr_pkg::AUTO_PRE_BIT];
        end
    end

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            mr_idx_o <= '0;
        end else if (is_mrs) begin
            mr_idx_o <= idx_nxt;
        end
    end

    // ------------------------------------------------------------
    // mode registers; only index zero steers the decode
    // ------------------------------------------------------------
    logic [cmd_addr_pkg::ADDR_W-1:0] mr_r [4];
    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                mr_r[i] <= cmd_addr_pkg::MR_RESET;
            end
        end else if (is_mrs) begin
            mr_r[idx_nxt] <= addr_r;
        end
    end
    assign mr0_r = mr_r[0];

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            mr0_o <= cmd_addr_pkg::MR_RESET;
        end else begin
            mr0_o <= mr0_r;
        end
    end

    // ------------------------------------------------------------
    // strobe: toggles on each rising edge while enabled, so its
    // edges stay locked to the clock; data path is not modelled
    // ------------------------------------------------------------
    logic dqs_r;
    logic dqs_n_r;
    logic dqs_oe_r;

    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            dqs_oe_r <= 1'b0;
        end else begin
            dqs_oe_r <= strobe_en_i;
        end
    end

    // both halves come from flops so the pair cannot skew apart
    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            dqs_r   <= 1'b0;
            dqs_n_r <= 1'b1;
        end else begin
            dqs_r   <= strobe_en_i ? !dqs_r : 1'b0;
            dqs_n_r <= strobe_en_i ? dqs_r : 1'b1;
        end
    end
    assign pins.dqs    = dqs_r;
    assign pins.dqs_n  = dqs_n_r;
    assign pins.dqs_oe = dqs_oe_r;
endmodule
`default_nettype wire

// [rtl/cmd_addr_ctrl.sv]
// controller end: turns a one-cycle user request into pin levels.
// assumes the device end samples pins on the next rising edge.
`timescale 1ns/1ps
`default_nettype none
module cmd_addr_ctrl (
    cmd_addr_if.ctrl                       pins,
    input  wire logic                      rst_i,
    input  wire logic                      req_i,
    input  wire cmd_addr_pkg::cmd_kind_t   kind_i,
    input  wire logic [cmd_addr_pkg::BANK_W-1:0] bank_i,
    input  wire logic [cmd_addr_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                      auto_pre_i,
    input  wire logic                      all_banks_i,
    input  wire logic                      burst8_i,
    output logic                           dqs_seen_o
);
    // ------------------------------------------------------------
    // address and command shaping
    // ------------------------------------------------------------
    wire is_rw = kind_i == cmd_addr_pkg::K_RD || kind_i == cmd_addr_pkg::K_WR;
    wire is_pre = kind_i == cmd_addr_pkg::K_PRE;
    logic [cmd_addr_pkg::ADDR_W-1:0] addr_nxt;
    always_comb begin
        addr_nxt = addr_i;
        if (is_rw) begin
            addr_nxt[cmd_addr_pkg::AUTO_PRE_BIT] = auto_pre_i;
            addr_nxt[cmd_addr_pkg::CHOP_SEL_BIT] = burst8_i;
        end
        if (is_pre) begin
            addr_nxt[cmd_addr_pkg::AUTO_PRE_BIT] = all_banks_i;
        end
    end

    logic [3:0] code_nxt;
    always_comb begin
        case (kind_i)
            cmd_addr_pkg::K_ACT: code_nxt = cmd_addr_pkg::CODE_ACT;
            cmd_addr_pkg::K_RD:  code_nxt = cmd_addr_pkg::CODE_RD;
            cmd_addr_pkg::K_WR:  code_nxt = cmd_addr_pkg::CODE_WR;
            cmd_addr_pkg::K_PRE: code_nxt = cmd_addr_pkg::CODE_PRE;
            cmd_addr_pkg::K_MRS: code_nxt = cmd_addr_pkg::CODE_MRS;
            cmd_addr_pkg::K_OTHER: code_nxt = cmd_addr_pkg::CODE_REF;
            default:             code_nxt = cmd_addr_pkg::CODE_NOP;
        endcase
        if (!req_i) begin
            code_nxt = cmd_addr_pkg::CODE_DESL;
        end
    end

    // ------------------------------------------------------------
    // pin registers
    // ------------------------------------------------------------
    logic [3:0]                      code_r;
    logic [cmd_addr_pkg::ADDR_W-1:0] addr_r;
    logic [cmd_addr_pkg::BANK_W-1:0] bank_r;
    always_ff @(posedge pins.ref_clk_i) begin
        if (rst_i) begin
            code_r     <= cmd_addr_pkg::CODE_DESL;
            addr_r     <= '0;
            bank_r     <= '0;
            dqs_seen_o <= 1'b0;
        end else begin
            code_r     <= code_nxt;
            addr_r     <= addr_nxt;
            bank_r     <= bank_i;
            dqs_seen_o <= pins.dqs_oe && pins.dqs && !pins.dqs_n;
        end
    end
    assign pins.cs_n  = code_r[3];
    assign pins.ras_n = code_r[2];
    assign pins.cas_n = code_r[1];
    assign pins.we_n  = code_r[0];
    assign pins.addr  = addr_r;
    assign pins.bank  = bank_r;
endmodule
`default_nettype wire

// [bench/cmd_addr_monitor.sv]
// checker: pin and decode relations across the command/address link.
// assumes it is instantiated beside the interface, names matching.
`timescale 1ns/1ps
`default_nettype none
module cmd_addr_monitor (
    input wire logic                              ref_clk_i,
    input wire logic                              rst_i,
    input wire logic                              cs_n,
    input wire logic                              ras_n,
    input wire logic                              cas_n,
    input wire logic                              we_n,
    input wire logic [cmd_addr_pkg::ADDR_W-1:0]   addr,
    input wire logic [cmd_addr_pkg::BANK_W-1:0]   bank,
    input wire logic                              dqs,
    input wire logic                              dqs_n,
    input wire logic                              dqs_oe,
    input wire logic                              cmd_valid_o,
    input wire cmd_addr_pkg::cmd_kind_t           cmd_kind_o,
    input wire logic [cmd_addr_pkg::BANK_W-1:0]   bank_o,
    input wire logic [cmd_addr_pkg::ADDR_W-1:0]   row_o,
    input wire logic                              auto_pre_o,
    input wire logic                              pre_all_o,
    input wire logic                              mr_load_o,
    input wire logic [cmd_addr_pkg::MR_IDX_W-1:0] mr_idx_o
);
    // ------------------------------------------------------------
    // pin command code seen at each rising edge
    // ------------------------------------------------------------
    wire logic [3:0] code = {cs_n, ras_n, cas_n, we_n};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_act;
        code == cmd_addr_pkg::CODE_ACT |-> ##2 cmd_valid_o
            && row_o == $past(addr, 2) && bank_o == $past(bank, 2);
    endproperty
    a_act: assert property (p_act)
        else $error("activate row or bank not taken");
    property p_desel;
        cs_n |-> ##2 !cmd_valid_o;
    endproperty
    a_desel: assert property (p_desel)
        else $error("deselected cycle produced a command");
    property p_pre;
        code == cmd_addr_pkg::CODE_PRE |-> ##2 cmd_valid_o
            && cmd_kind_o == cmd_addr_pkg::K_PRE
            && pre_all_o == $past(addr[10], 2);
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharge scope wrong");
    property p_rdwr;
        (code == cmd_addr_pkg::CODE_RD || code == cmd_addr_pkg::CODE_WR)
            |-> ##2 cmd_valid_o && auto_pre_o == $past(addr[10], 2);
    endproperty
    a_rdwr: assert property (p_rdwr)
        else $error("auto precharge flag wrong");
    property p_mrs;
        code == cmd_addr_pkg::CODE_MRS |-> ##2 mr_load_o
            && mr_idx_o == $past(bank[1:0], 2);
    endproperty
    a_mrs: assert property (p_mrs)
        else $error("mode register index wrong");
    property p_cause;
        cmd_valid_o |-> $past(!cs_n, 2);
    endproperty
    a_cause: assert property (p_cause)
        else $error("command without chip select");
    property p_pair;
        dqs_oe |-> dqs_n == !dqs;
    endproperty
    a_pair: assert property (p_pair)
        else $error("strobe pair not complementary");
    property p_toggle;
        dqs_oe && $past(dqs_oe) |-> dqs != $past(dqs);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("strobe missed a clock edge");
endmodule
`default_nettype wire

// [bench/ddr3_cmd_addr_decode_tb.sv]
// testbench: controller end driving the decode end over the interface.
// assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ddr3_cmd_addr_decode_tb;
    typedef struct packed {
        cmd_addr_pkg::cmd_kind_t kind;
        logic [2:0]              bank;
        logic [13:0]             val;
        logic                    ap;
        logic                    b8;
    } note_t;
    logic                    ref_clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    req_i = 1'b0;
    logic                    strobe_en_i = 1'b0;
    cmd_addr_pkg::cmd_kind_t kind_i = cmd_addr_pkg::K_NONE;
    logic [2:0]              bank_i = 3'h0;
    logic [13:0]             addr_i = 14'h0;
    logic                    auto_pre_i = 1'b0;
    logic                    all_banks_i = 1'b0;
    logic                    burst8_i = 1'b0;
    logic                    cmd_valid_o, auto_pre_o, pre_all_o;
    logic                    burst8_o, mr_load_o, dqs_seen_o;
    cmd_addr_pkg::cmd_kind_t cmd_kind_o;
    logic [2:0]              bank_o;
    logic [1:0]              mr_idx_o;
    logic [13:0]             row_o, col_o, mr0_o, op;
    logic [1:0]              mode = cmd_addr_pkg::BL_FIXED8;
    logic [1:0]              modes [3];
    note_t                   q [$];
    note_t                   got;
    logic                    strobe_hit = 1'b0;
    int                      err_count = 0;
    int                      num_checks = 0;
    int                      cycles = 0;

    initial forever #12.5 ref_clk_i = ~ref_clk_i;

    cmd_addr_if cmd_addr_if_i (.ref_clk_i(ref_clk_i));
    cmd_addr_ctrl cmd_addr_ctrl_i (.pins(cmd_addr_if_i), .rst_i(rst_i),
        .req_i(req_i), .kind_i(kind_i), .bank_i(bank_i), .addr_i(addr_i),
        .auto_pre_i(auto_pre_i), .all_banks_i(all_banks_i),
        .burst8_i(burst8_i), .dqs_seen_o(dqs_seen_o));
    cmd_addr_decode cmd_addr_decode_i (.pins(cmd_addr_if_i), .rst_i(rst_i),
        .strobe_en_i(strobe_en_i), .cmd_valid_o(cmd_valid_o),
        .cmd_kind_o(cmd_kind_o), .bank_o(bank_o), .row_o(row_o),
        .col_o(col_o), .auto_pre_o(auto_pre_o), .pre_all_o(pre_all_o),
        .burst8_o(burst8_o), .mr_load_o(mr_load_o), .mr_idx_o(mr_idx_o),
        .mr0_o(mr0_o));
    cmd_addr_monitor cmd_addr_monitor_i (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .cs_n(cmd_addr_if_i.cs_n),
        .ras_n(cmd_addr_if_i.ras_n), .cas_n(cmd_addr_if_i.cas_n),
        .we_n(cmd_addr_if_i.we_n), .addr(cmd_addr_if_i.addr),
        .bank(cmd_addr_if_i.bank), .dqs(cmd_addr_if_i.dqs),
        .dqs_n(cmd_addr_if_i.dqs_n), .dqs_oe(cmd_addr_if_i.dqs_oe),
        .cmd_valid_o(cmd_valid_o), .cmd_kind_o(cmd_kind_o),
        .bank_o(bank_o), .row_o(row_o), .auto_pre_o(auto_pre_o),
        .pre_all_o(pre_all_o), .mr_load_o(mr_load_o), .mr_idx_o(mr_idx_o));

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // expected burst length is fixed here, from the mode held at request
    task automatic send(input cmd_addr_pkg::cmd_kind_t k, input logic [2:0] b,
                        input logic [13:0] a, input logic ap, input logic b8);
        logic e8;
        @(posedge ref_clk_i);
        req_i       <= 1'b1;
        kind_i      <= k;
        bank_i      <= b;
        addr_i      <= a;
        auto_pre_i  <= ap;
        all_banks_i <= ap;
        burst8_i    <= b8;
        e8 = (mode == cmd_addr_pkg::BL_OTF) ? b8
            : (mode != cmd_addr_pkg::BL_FIXED4);
        q.push_back({k, b, a, ap, e8});
    endtask

    // idle cycles scramble the bank and address fields to prove they are masked
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            req_i <= 1'b0;
            {bank_i, addr_i} <= 17'($urandom);
        end
    endtask

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(negedge ref_clk_i) begin
        if (dqs_seen_o === 1'b1) begin
            strobe_hit = 1'b1;
        end
        if (!rst_i && cmd_valid_o !== 1'b0) begin
            if (q.size() == 0) begin
                check(14'h1, 14'h0);
            end else begin
                got = q.pop_front();
                check(14'(cmd_kind_o), 14'(got.kind));
                case (got.kind)
                    cmd_addr_pkg::K_ACT: begin
                        check(row_o, got.val);
                        check(14'(bank_o), 14'(got.bank));
                    end
                    cmd_addr_pkg::K_RD, cmd_addr_pkg::K_WR: begin
                        check(14'(col_o[9:0]), 14'(got.val[9:0]));
                        check(14'(auto_pre_o), 14'(got.ap));
                        check(14'(burst8_o), 14'(got.b8));
                        check(14'(bank_o), 14'(got.bank));
                    end
                    cmd_addr_pkg::K_PRE: begin
                        check(14'(pre_all_o), 14'(got.ap));
                        if (!got.ap) check(14'(bank_o), 14'(got.bank));
                    end
                    cmd_addr_pkg::K_MRS: begin
                        check(14'(mr_load_o), 14'h1);
                        check(14'(mr_idx_o), 14'(got.bank[1:0]));
                    end
                    default: ;
                endcase
            end
        end
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        modes = '{cmd_addr_pkg::BL_OTF, cmd_addr_pkg::BL_FIXED4,
                  cmd_addr_pkg::BL_FIXED8};
        void'($urandom(8));
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        strobe_en_i <= 1'b1;
        @(negedge ref_clk_i);
        check(mr0_o, cmd_addr_pkg::MR_RESET);
        send(cmd_addr_pkg::K_RD, 3'h1, 14'h0, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            send(cmd_addr_pkg::K_ACT, 3'(i), 14'($urandom), 1'b0, 1'b0);
        end
        idle(3);
        send(cmd_addr_pkg::K_PRE, 3'h5, 14'($urandom), 1'b0, 1'b0);
        send(cmd_addr_pkg::K_PRE, 3'h2, 14'($urandom), 1'b1, 1'b0);
        send(cmd_addr_pkg::K_OTHER, 3'h0, 14'h0, 1'b0, 1'b0);
        for (int i = 3; i > 0; i--) begin
            send(cmd_addr_pkg::K_MRS, 3'(i + 4), 14'($urandom), 1'b0, 1'b0);
        end
        strobe_en_i <= 1'b0;
        foreach (modes[m]) begin
            op = {12'($urandom), modes[m]};
            send(cmd_addr_pkg::K_MRS, 3'h4, op, 1'b0, 1'b0);
            mode = modes[m];
            idle(4);
            @(negedge ref_clk_i);
            check(mr0_o, op);
            check(14'(strobe_hit), 14'h1);
            check(14'(dqs_seen_o), 14'h0);
            for (int i = 0; i < 6; i++) begin
                send(i[0] ? cmd_addr_pkg::K_RD : cmd_addr_pkg::K_WR,
                     3'($urandom), 14'($urandom), 1'($urandom), 1'($urandom));
            end
            idle(2);
        end
        idle(6);
        check(14'(q.size()), 14'h0);
        close_out();
    end
endmodule
`default_nettype wire
